// [hw/digital_input_conditioning.sv]
// Digital input conditioning: sampling, forcing, inversion, special
// functions and optional routing into the 32-bit input image.
// Assumes pins are asynchronous and config arrives on ref_clk.
//
// Overview of operation
// - Special-function bits sit only in image bits 0 to 15.
// - Plain levels sit in image bits 16 to 31, channel order.
// - Negative limit of input one shows on image bit 0 when enabled.
// - Image bit 16 shows input one level whatever the enable.
// - Inputs are sampled once per millisecond; shorter pulses may vanish.
// - Inputs one to three: negative limit, positive limit/direction, home/step.
// - Threshold bit per input: 0 selects 5 V, 1 selects 24 V.
// - Differential select 1 gives three differential inputs, 0 six single.
// - Enable word bits 0..3: negative, positive, home, interlock.
// - The enable word never touches level bits 16 to 31.
// - Inversion bit 0 normally open, 1 normally closed, per input.
// - Inversion applies to levels and special functions, not step or direction.
// - Force-enable bit substitutes a software value for the sampled one.
// - Force-value bit gives the value read while forcing.
// - Raw word shows sampled levels before forcing and inversion.
// - Conditioned input one lands in bit 16; bit 0 means negative limit.
// - Routing mode drives each image bit from a chosen source.
// - Routing becomes active when routing enable is written 1.
// - Enabling routing loads the table with the previous fixed mapping.
// - Entry n picks bit n source; 00 zero, 01-10 inputs, 80 inverts.
// - Enabled interlock reading 0 raises the error state; 1 permits motion.
`timescale 1ns/1ps

module digital_input_conditioning
  import din_cond_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [NUM_IN-1:0] pin_in,
  input  wire logic [2:0]        enc_in,
  input  wire od_req_t           od_req,
  output logic                   od_ack,
  output logic [31:0]            od_rdata,
  output logic [NUM_IN-1:0]      threshold_24v,
  output logic                   diff_mode,
  output logic [IMG_W-1:0]       input_image,
  output logic                   neg_limit,
  output logic                   pos_limit,
  output logic                   home_switch,
  output logic                   step_dir,
  output logic                   step_clk,
  output logic                   interlock_fault
);

  logic [NUM_IN-1:0] pin_meta;
  logic [NUM_IN-1:0] pin_sync;
  logic [2:0]        enc_meta;
  logic [2:0]        enc_sync;
  logic [31:0]       tick_cnt;
  logic              tick;
  logic [NUM_IN-1:0] raw;
  logic [31:0]       special_function_enable;
  logic [31:0]       input_invert_select;
  logic [31:0]       input_force_enable;
  logic [31:0]       input_force_value;
  logic [31:0]       input_threshold_select;
  logic              differential_mode_select;
  logic              input_routing_enable;
  logic [7:0]        input_routing_table [ROUTE_N];
  logic [NUM_IN-1:0] front;
  logic [NUM_IN-1:0] forced;
  logic [NUM_IN-1:0] level;
  logic [IMG_W-1:0]  fixed_image;
  logic [IMG_W-1:0]  routed_image;
  logic [IMG_W-1:0]  next_image;
  logic              load_default;
  logic              wr_spec_en;
  logic              wr_invert;
  logic              wr_force_en;
  logic              wr_force_val;
  logic              wr_thresh;
  logic              wr_diff;
  logic              wr_route_en;

  // Two-stage synchronisers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
      enc_meta <= '0;
      enc_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      enc_meta <= enc_in;
      enc_sync <= enc_meta;
    end
  end

  // Millisecond sample tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  assign tick = (tick_cnt == 32'(SAMPLE_CYCLES - 1));

  // Differential pairs: channel k is high when pin 2k+1 is high and pin 2k is low
  always_comb begin
    front = pin_sync;
    if (differential_mode_select) begin
      front = '0;
      for (int k = 0; k < NUM_IN / 2; k++) begin
        front[k] = pin_sync[2*k+1] & ~pin_sync[2*k];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      raw <= '0;
    end else if (tick) begin
      raw <= front;
    end
  end

  // Force then invert, per input
  for (genvar i = 0; i < NUM_IN; i++) begin : g_cond
    assign forced[i] = input_force_enable[i] ? input_force_value[i] : raw[i];
    assign level[i]  = forced[i] ^ input_invert_select[i];
  end

  // Fixed assignment of the image
  always_comb begin
    fixed_image = '0;
    fixed_image[LEVEL_BASE +: NUM_IN] = level;
    fixed_image[BIT_NEG_LIM] = level[0] & special_function_enable[BIT_NEG_LIM];
    fixed_image[BIT_POS_LIM] = level[1] & special_function_enable[BIT_POS_LIM];
    fixed_image[BIT_HOME]    = level[2] & special_function_enable[BIT_HOME];
    fixed_image[BIT_ILOCK]   = 1'b0;
  end

  // Routed image, one selector per bit
  for (genvar b = 0; b < IMG_W; b++) begin : g_route
    logic [6:0] code;
    logic       src;
    assign code = input_routing_table[b][6:0];
    always_comb begin
      src = 1'b0;
      if (code >= SRC_IN_FIRST && code <= SRC_IN_LAST) begin
        for (int k = 0; k < NUM_IN; k++) begin
          if (code == 7'(k + 1)) begin
            src = level[k];
          end
        end
      end else if (code == SRC_ENC_A) begin
        src = enc_sync[0];
      end else if (code == SRC_ENC_B) begin
        src = enc_sync[1];
      end else if (code == SRC_ENC_IDX) begin
        src = enc_sync[2];
      end
    end
    if (b < NUM_SPEC) begin : g_spec
      assign routed_image[b] = (src ^ input_routing_table[b][SRC_INV_BIT])
                               & special_function_enable[b];
    end else begin : g_plain
      assign routed_image[b] = src ^ input_routing_table[b][SRC_INV_BIT];
    end
  end

  assign next_image = input_routing_enable ? routed_image : fixed_image;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_image <= '0;
    end else begin
      input_image <= next_image;
    end
  end

  // Configuration writes: one strobe and one register per object
  assign wr_spec_en   = od_req.wr && (od_req.idx == IDX_SPEC_EN);
  assign wr_invert    = od_req.wr && (od_req.idx == IDX_INVERT);
  assign wr_force_en  = od_req.wr && (od_req.idx == IDX_FORCE_EN);
  assign wr_force_val = od_req.wr && (od_req.idx == IDX_FORCE_VAL);
  assign wr_thresh    = od_req.wr && (od_req.idx == IDX_THRESH);
  assign wr_diff      = od_req.wr && (od_req.idx == IDX_DIFF);
  assign wr_route_en  = od_req.wr && (od_req.idx == IDX_ROUTE_EN);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      special_function_enable <= RST_CFG;
    end else if (wr_spec_en) begin
      special_function_enable <= od_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_invert_select <= RST_CFG;
    end else if (wr_invert) begin
      input_invert_select <= od_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_force_enable <= RST_CFG;
    end else if (wr_force_en) begin
      input_force_enable <= od_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_force_value <= RST_CFG;
    end else if (wr_force_val) begin
      input_force_value <= od_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_threshold_select <= RST_CFG;
    end else if (wr_thresh) begin
      input_threshold_select <= od_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      differential_mode_select <= 1'b0;
    end else if (wr_diff) begin
      differential_mode_select <= od_req.wdata[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_routing_enable <= 1'b0;
    end else if (wr_route_en) begin
      input_routing_enable <= od_req.wdata[0];
    end
  end

  // Defaults load only on the off-to-on step, so a repeated enable keeps user entries
  assign load_default = wr_route_en && od_req.wdata[0] && !input_routing_enable;

  // Routing table: default load reproduces the fixed mapping
  for (genvar b = 0; b < ROUTE_N; b++) begin : g_table
    localparam logic [7:0] DEF =
      (b < NUM_SPEC - 1) ? 8'(b + 1) :
      (b >= LEVEL_BASE && b < LEVEL_BASE + NUM_IN) ? 8'(b - LEVEL_BASE + 1) : SRC_ZERO;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        input_routing_table[b] <= RST_ROUTE;
      end else if (load_default) begin
        input_routing_table[b] <= DEF;
      end else if (od_req.wr && od_req.idx == IDX_ROUTE_BASE + 6'(b)) begin
        input_routing_table[b] <= od_req.wdata[7:0];
      end
    end
  end

  // Read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      od_ack   <= 1'b0;
      od_rdata <= '0;
    end else begin
      od_ack <= od_req.rd | od_req.wr;
      if (od_req.rd) begin
        od_rdata <= '0;
        if (od_req.idx >= IDX_ROUTE_BASE) begin
          od_rdata <= {24'h00_0000, input_routing_table[5'(od_req.idx - IDX_ROUTE_BASE)]};
        end else begin
          unique case (od_req.idx)
            IDX_SPEC_EN:   od_rdata <= special_function_enable;
            IDX_INVERT:    od_rdata <= input_invert_select;
            IDX_FORCE_EN:  od_rdata <= input_force_enable;
            IDX_FORCE_VAL: od_rdata <= input_force_value;
            IDX_RAW:       od_rdata <= {26'h000_0000, raw};
            IDX_THRESH:    od_rdata <= input_threshold_select;
            IDX_DIFF:      od_rdata <= {31'h0000_0000, differential_mode_select};
            IDX_ROUTE_EN:  od_rdata <= {31'h0000_0000, input_routing_enable};
            IDX_IMAGE:     od_rdata <= input_image;
            default:       od_rdata <= '0;
          endcase
        end
      end
    end
  end

  // Front-end controls follow the configuration one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      threshold_24v <= '0;
      diff_mode     <= 1'b0;
    end else begin
      threshold_24v <= input_threshold_select[NUM_IN-1:0];
      diff_mode     <= differential_mode_select;
    end
  end

  // Switch outputs trail the image by one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neg_limit   <= 1'b0;
      pos_limit   <= 1'b0;
      home_switch <= 1'b0;
    end else begin
      neg_limit   <= input_image[BIT_NEG_LIM];
      pos_limit   <= input_image[BIT_POS_LIM];
      home_switch <= input_image[BIT_HOME];
    end
  end

  // Step and direction bypass inversion but honour forcing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      step_dir <= 1'b0;
      step_clk <= 1'b0;
    end else begin
      step_dir <= forced[1];
      step_clk <= forced[2];
    end
  end

  // Only an enabled interlock whose image bit reads 0 stops motion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interlock_fault <= 1'b0;
    end else begin
      interlock_fault <= special_function_enable[BIT_ILOCK] & ~input_image[BIT_ILOCK];
    end
  end

endmodule // digital_input_conditioning

// [hw/din_cond_pkg.sv]
// Package for the digital input conditioning block: object map, field
// positions, reset values, routing source codes and the sample timing.
package din_cond_pkg;

  localparam int NUM_IN   = 6;
  localparam int IMG_W    = 32;
  localparam int ROUTE_N  = 32;

  // Object index map of the configuration port
  localparam logic [5:0] IDX_SPEC_EN    = 6'h01;
  localparam logic [5:0] IDX_INVERT     = 6'h02;
  localparam logic [5:0] IDX_FORCE_EN   = 6'h03;
  localparam logic [5:0] IDX_FORCE_VAL  = 6'h04;
  localparam logic [5:0] IDX_RAW        = 6'h05;
  localparam logic [5:0] IDX_THRESH     = 6'h06;
  localparam logic [5:0] IDX_DIFF       = 6'h07;
  localparam logic [5:0] IDX_ROUTE_EN   = 6'h08;
  localparam logic [5:0] IDX_IMAGE      = 6'h09;
  localparam logic [5:0] IDX_ROUTE_BASE = 6'h20;

  // Image layout
  localparam int LEVEL_BASE  = 16;
  localparam int BIT_NEG_LIM = 0;
  localparam int BIT_POS_LIM = 1;
  localparam int BIT_HOME    = 2;
  localparam int BIT_ILOCK   = 3;
  localparam int NUM_SPEC    = 4;

  // Routing source codes
  localparam logic [7:0] SRC_ZERO     = 8'h00;
  localparam logic [6:0] SRC_IN_FIRST = 7'h01;
  localparam logic [6:0] SRC_IN_LAST  = 7'h10;
  localparam logic [6:0] SRC_ENC_A    = 7'h44;
  localparam logic [6:0] SRC_ENC_B    = 7'h45;
  localparam logic [6:0] SRC_ENC_IDX  = 7'h46;
  localparam int         SRC_INV_BIT  = 7;

  // Reset values
  localparam logic [31:0] RST_CFG   = 32'h0000_0000;
  localparam logic [7:0]  RST_ROUTE = 8'h00;

  // Sample period
  localparam int CLK_HZ       = 250_000_000;
  localparam int SAMPLE_US    = 1000;
  localparam int SAMPLE_CYC   = CLK_HZ / 1_000_000 * SAMPLE_US;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  idx;
    logic [31:0] wdata;
  } od_req_t;

endpackage

// [tb/din_cond_monitor.sv]
// Checker for the input conditioning block: config handshake and outputs.
// Sees only the top module ports; attached by bind from the testbench.
`timescale 1ns/1ps
module din_monitor
  import din_cond_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire od_req_t     od_req,
  input wire logic        od_ack,
  input wire logic [31:0] od_rdata,
  input wire logic [5:0]  threshold_24v,
  input wire logic        diff_mode,
  input wire logic [31:0] input_image,
  input wire logic        neg_limit,
  input wire logic        pos_limit,
  input wire logic        home_switch,
  input wire logic        interlock_fault
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic req = od_req.wr || od_req.rd;
  wire logic gap = od_req.idx == 6'h00 || (od_req.idx > IDX_IMAGE && od_req.idx < IDX_ROUTE_BASE);
  ack_after_req_a: assert property (req |=> od_ack)
    else $error("config access not acknowledged");
  ack_has_cause_a: assert property (od_ack |-> $past(req))
    else $error("acknowledge without access");
  spec_outputs_a: assert property ({home_switch, pos_limit, neg_limit} == $past(input_image[2:0]))
    else $error("special outputs differ from image");
  unmapped_read_a: assert property (od_req.rd && gap |=> od_rdata == 32'h0)
    else $error("unmapped read not zero");
  read_data_hold_a: assert property (!od_req.rd |=> $stable(od_rdata))
    else $error("read data moved without read");
  interlock_ok_a: assert property (input_image[3] |=> !interlock_fault)
    else $error("fault with interlock released");
  diff_by_write_a: assert property ($changed(diff_mode) |-> $past(od_req.wr, 2) && $past(od_req.idx, 2) == IDX_DIFF)
    else $error("differential mode moved without write");
  range_by_write_a: assert property ($changed(threshold_24v) |-> $past(od_req.wr, 2) && $past(od_req.idx, 2) == IDX_THRESH)
    else $error("threshold moved without write");
  cover property (interlock_fault);
  cover property (diff_mode && od_ack);
  cover property (neg_limit && input_image[16]);
endmodule // din_monitor

// [tb/input_sources.sv]
// Switches and sensors facing the conditioning inputs.
// Levels are commanded by the bench and change just after a clock edge.
`timescale 1ns/1ps
module input_sources (
  input  wire logic       ref_clk,
  input  wire logic [5:0] want_pins,
  input  wire logic [2:0] want_enc,
  output logic      [5:0] pin_in,
  output logic      [2:0] enc_in
);
  always_ff @(posedge ref_clk) begin
    pin_in <= want_pins;
    enc_in <= want_enc;
  end
endmodule // input_sources

// [tb/testbench.sv]
// Testbench for the input conditioning block: config port tasks and tests.
// Assumes package, design, checker and source model are compiled first.
`timescale 1ns/1ps
module testbench;
  import din_cond_pkg::*;
  localparam int SC = 16;
  logic        ref_clk, rst, ack, dm, ilk, nl, pl, hs, sd, sk;
  logic [5:0]  want, pin_in, thr;
  logic [2:0]  want_enc, enc_in;
  logic [31:0] rdata, img, q;
  od_req_t     od_req;
  int          errors, cmp_count;
  logic [7:0]  code [7] = '{8'h00, 8'h04, 8'h84, 8'h80, 8'h44, 8'hC4, 8'h11};
  logic [6:0]  bit31 = 7'h1A;

  input_sources SRC (.ref_clk(ref_clk), .want_pins(want), .want_enc(want_enc),
    .pin_in(pin_in), .enc_in(enc_in));
  digital_input_conditioning #(.SAMPLE_CYCLES(SC)) DUT (.ref_clk(ref_clk), .rst(rst),
    .pin_in(pin_in), .enc_in(enc_in), .od_req(od_req), .od_ack(ack), .od_rdata(rdata),
    .threshold_24v(thr), .diff_mode(dm), .input_image(img), .neg_limit(nl),
    .pos_limit(pl), .home_switch(hs), .step_dir(sd), .step_clk(sk), .interlock_fault(ilk));

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One access: request for one cycle, answer in the following cycle
  task automatic acc(logic w, logic [5:0] idx, logic [31:0] d);
    int n;
    @(posedge ref_clk);
    od_req <= '{w, !w, idx, d};
    @(posedge ref_clk);
    od_req <= '0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 8);
    if (ack !== 1'b1) begin
      errors++;
      give_verdict();
    end
    q = rdata;
  endtask

  task automatic wr(logic [5:0] idx, logic [31:0] d);
    acc(1'b1, idx, d);
  endtask

  task automatic rd(string what, logic [5:0] idx, logic [31:0] e);
    acc(1'b0, idx, 32'h0);
    chk(what, q, e);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    od_req = '0;
    want = 6'h00;
    want_enc = 3'h0;
    errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 1; i <= 9; i++) rd("reset", i[5:0], 32'h0);
    $display("test reset done");
    want <= 6'h2D;
    want_enc <= 3'h1;
    repeat (SC + 6) @(posedge ref_clk);
    rd("raw", IDX_RAW, 32'h2D);
    rd("levels", IDX_IMAGE, 32'h002D_0000);
    wr(IDX_SPEC_EN, 32'h7);
    rd("spec", IDX_IMAGE, 32'h002D_0005);
    chk("switches", {hs, pl, nl}, 3'h5);
    wr(IDX_SPEC_EN, 32'hF);
    repeat (3) @(posedge ref_clk);
    chk("ilock", ilk, 1'b1);
    $display("test levels done");
    wr(IDX_INVERT, 32'h3F);
    rd("invert", IDX_IMAGE, 32'h0012_0002);
    chk("step", {sk, sd}, 2'h2);
    wr(IDX_FORCE_EN, 32'h1);
    wr(IDX_FORCE_VAL, 32'h0);
    rd("force", IDX_IMAGE, 32'h0013_0003);
    wr(IDX_FORCE_VAL, 32'h1);
    rd("force1", IDX_IMAGE, 32'h0012_0002);
    rd("rawf", IDX_RAW, 32'h2D);
    $display("test condition done");
    wr(IDX_THRESH, 32'h2A);
    @(posedge ref_clk);
    chk("thr", thr, 6'h2A);
    wr(IDX_DIFF, 32'h1);
    @(posedge ref_clk);
    chk("diff", dm, 1'b1);
    repeat (SC + 4) @(posedge ref_clk);
    rd("diffimg", IDX_IMAGE, 32'h003A_0002);
    wr(IDX_DIFF, 32'h0);
    @(posedge ref_clk);
    chk("single", dm, 1'b0);
    repeat (SC + 4) @(posedge ref_clk);
    wr(IDX_INVERT, 32'h0);
    wr(IDX_FORCE_EN, 32'h0);
    // Routing is switched on once only
    wr(IDX_ROUTE_EN, 32'h1);
    rd("keep", IDX_IMAGE, 32'h002D_0005);
    rd("ent0", IDX_ROUTE_BASE, 32'h01);
    rd("ent21", 6'h35, 32'h06);
    wr(6'h23, 32'h80);
    rd("ilkon", IDX_IMAGE, 32'h002D_000D);
    for (int i = 0; i < 7; i++) begin
      wr(6'h3F, {24'h0, code[i]});
      acc(1'b0, IDX_IMAGE, 32'h0);
      chk("route", q[31], bit31[i]);
    end
    $display("test routing done");
    rd("gap", 6'h0A, 32'h0);
    wr(IDX_RAW, 32'hFF);
    rd("raw_ro", IDX_RAW, 32'h2D);
    $display("test access done");
    give_verdict();
  end
endmodule // testbench

bind digital_input_conditioning din_monitor MON (.ref_clk(ref_clk), .rst(rst),
  .od_req(od_req), .od_ack(od_ack), .od_rdata(od_rdata), .threshold_24v(threshold_24v),
  .diff_mode(diff_mode), .input_image(input_image), .neg_limit(neg_limit),
  .pos_limit(pos_limit), .home_switch(home_switch), .interlock_fault(interlock_fault));
